/* File: rtl/pcsp_defs.svh */
// Timing counts, address codes and idle reply level of the pad card serial port.
`ifndef PCSP_DEFS_SVH
`define PCSP_DEFS_SVH

`define PCSP_CLK_MHZ         125
`define PCSP_ACK_LOW_NS      2000
`define PCSP_ACK_LOW_CYC     ((`PCSP_ACK_LOW_NS * `PCSP_CLK_MHZ + 999) / 1000)
`define PCSP_ACK_DELAY_NS    4000
`define PCSP_ACK_DELAY_CYC   ((`PCSP_ACK_DELAY_NS * `PCSP_CLK_MHZ + 999) / 1000)
`define PCSP_ADDR_PAD        8'h01
`define PCSP_ADDR_CARD       8'h81
`define PCSP_ADDR_RX_A       8'h21
`define PCSP_ADDR_RX_B       8'h61
`define PCSP_IDLE_REPLY      1'b1

`endif

/* File: rtl/pcsp_pkg.sv */
// Types shared by the pad card serial port modules.
package pcsp_pkg;
  typedef enum logic [1:0] {
    PCSP_ST_IDLE,
    PCSP_ST_DELAY,
    PCSP_ST_ACK
  } pcsp_ack_state_t;
endpackage

/* File: rtl/pcsp_xfer_if.sv */
// Byte hand-over between the link-clock shifter and the system-clock control.
`timescale 1ns/1ps
interface pcsp_xfer_if;
  logic       done_tgl;
  logic [7:0] rx_byte;
  logic       addr_phase;
  logic       sel_n;
  logic       tx_tgl;
  logic [7:0] tx_byte;
  logic       drive_en;
  modport link (output done_tgl, rx_byte, addr_phase, sel_n, input tx_tgl, tx_byte, drive_en);
  modport ctrl (input done_tgl, rx_byte, addr_phase, sel_n, output tx_tgl, tx_byte, drive_en);
endinterface

/* File: rtl/pcsp_link_shift.sv */
// Link-clock shift logic: full-duplex byte exchange on the host serial clock.
`timescale 1ns/1ps
`include "pcsp_defs.svh"
module pcsp_link_shift (
  // Link pins
  input  wire logic     link_clk_in,
  input  wire logic     port_select_n_in,
  input  wire logic     cmd_in,
  output logic          shared_reply_line_out,
  output logic          shared_reply_line_oe_out,
  // Control side
  pcsp_xfer_if.link     xf
);
  logic [2:0] bit_cnt;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic       first;
  logic       tx_seen;
  logic       byte_start;

  assign xf.sel_n   = port_select_n_in;
  assign byte_start = (bit_cnt == 3'd0) && !first;

  // The link clock stops between frames, so select high must clear the count at once.
  always_ff @(posedge link_clk_in or posedge port_select_n_in) begin
    if (port_select_n_in) begin
      bit_cnt     <= 3'd0;
      rx_sh       <= 8'h00;
      xf.done_tgl <= 1'b0;
    end else begin
      bit_cnt <= bit_cnt + 3'd1;
      rx_sh   <= {cmd_in, rx_sh[7:1]};
      if (bit_cnt == 3'd7) begin
        xf.rx_byte  <= {cmd_in, rx_sh[7:1]};
        xf.done_tgl <= ~xf.done_tgl;
      end
    end
  end

  // Reply bits change on falling edges. The toggle, byte and enable from the system clock
  // settle during the acknowledge pause, microseconds before the next byte starts, so the
  // handshake makes them safe to read here; the link clock is too sparse to synchronise.
  // Select high releases the reply line at once, so a deselected port never drives it.
  always_ff @(negedge link_clk_in or posedge port_select_n_in) begin
    if (port_select_n_in) begin
      first                    <= 1'b1;
      xf.addr_phase            <= 1'b1;
      tx_seen                  <= 1'b0;
      tx_sh                    <= 8'hff;
      shared_reply_line_out    <= `PCSP_IDLE_REPLY;
      shared_reply_line_oe_out <= 1'b0;
    end else begin
      first <= 1'b0;
      if (byte_start) xf.addr_phase <= 1'b0;
      if (byte_start && xf.tx_tgl != tx_seen) begin
        tx_seen               <= xf.tx_tgl;
        tx_sh                 <= {1'b1, xf.tx_byte[7:1]};
        shared_reply_line_out <= xf.tx_byte[0];
      end else begin
        tx_sh                 <= {1'b1, tx_sh[7:1]};
        shared_reply_line_out <= tx_sh[0];
      end
      shared_reply_line_oe_out <= xf.drive_en && (byte_start || !xf.addr_phase);
    end
  end
endmodule

/* File: rtl/pcsp_port.sv */
// Peripheral end of the pad card serial port: addressing, acknowledge, reply bytes.
`timescale 1ns/1ps
`include "pcsp_defs.svh"
module pcsp_port #(
  parameter logic [7:0] DEV_ADDR = `PCSP_ADDR_PAD
) (
  // System clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       resetn_in,
  // Link pins
  input  wire logic       link_clk_in,
  input  wire logic       port_select_n_in,
  input  wire logic       cmd_in,
  output logic            shared_reply_line_out,
  output logic            shared_reply_line_oe_out,
  output logic            ack_n_out,
  output logic            ack_n_oe_out,
  // User side
  input  wire logic [7:0] reply_byte_in,
  input  wire logic       reply_last_in,
  output logic [7:0]      cmd_byte_out,
  output logic            cmd_valid_out,
  output logic            selected_out
);
  pcsp_xfer_if xf ();

  pcsp_link_shift u_shift (
    .link_clk_in              (link_clk_in),
    .port_select_n_in         (port_select_n_in),
    .cmd_in                   (cmd_in),
    .shared_reply_line_out    (shared_reply_line_out),
    .shared_reply_line_oe_out (shared_reply_line_oe_out),
    .xf                       (xf)
  );

  // Crossings into the system clock.
  logic [2:0] done_s;
  logic [1:0] sel_s;
  logic [1:0] addrp_s;
  always_ff @(posedge sys_clk_in) begin
    done_s  <= {done_s[1:0], xf.done_tgl};
    sel_s   <= {sel_s[0], xf.sel_n};
    addrp_s <= {addrp_s[0], xf.addr_phase};
  end
  wire byte_done = done_s[2] ^ done_s[1];
  wire sel_n_s   = sel_s[1];

  pcsp_pkg::pcsp_ack_state_t state;
  pcsp_pkg::pcsp_ack_state_t next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        active;
  logic        next_active;
  logic        last;
  logic        next_last;
  logic        tx_tgl;
  logic        next_tx_tgl;
  logic [7:0]  tx_byte;
  logic [7:0]  next_tx_byte;
  logic        got_addr;
  logic        next_got_addr;

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_active   = active;
    next_last     = last;
    next_tx_tgl   = tx_tgl;
    next_tx_byte  = tx_byte;
    next_got_addr = got_addr;
    if (sel_n_s) begin
      next_state    = pcsp_pkg::PCSP_ST_IDLE;
      next_active   = 1'b0;
      next_tx_tgl   = 1'b0;
      next_last     = 1'b0;
      next_got_addr = 1'b0;
    end else if (byte_done) begin
      if (!got_addr) begin
        next_got_addr = 1'b1;
        if (xf.rx_byte == DEV_ADDR) begin
          next_active = 1'b1;
        end
      end
      if ((!got_addr && xf.rx_byte == DEV_ADDR) || (got_addr && active && !last)) begin
        next_tx_byte = reply_byte_in;
        next_tx_tgl  = ~tx_tgl;
        next_last    = reply_last_in;
        next_state   = pcsp_pkg::PCSP_ST_DELAY;
        next_cnt     = 16'(`PCSP_ACK_DELAY_CYC);
      end else begin
        next_active = 1'b0;
      end
    end else begin
      unique case (state)
        pcsp_pkg::PCSP_ST_IDLE: begin
        end
        pcsp_pkg::PCSP_ST_DELAY: begin
          if (cnt <= 16'd1) begin
            next_state = pcsp_pkg::PCSP_ST_ACK;
            next_cnt   = 16'(`PCSP_ACK_LOW_CYC);
          end else begin
            next_cnt = cnt - 16'd1;
          end
        end
        pcsp_pkg::PCSP_ST_ACK: begin
          if (cnt <= 16'd1) begin
            next_state = pcsp_pkg::PCSP_ST_IDLE;
          end else begin
            next_cnt = cnt - 16'd1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      state    <= pcsp_pkg::PCSP_ST_IDLE;
      cnt      <= 16'h0000;
      active   <= 1'b0;
      last     <= 1'b0;
      tx_tgl   <= 1'b0;
      tx_byte  <= 8'h00;
      got_addr <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      active   <= next_active;
      last     <= next_last;
      tx_tgl   <= next_tx_tgl;
      tx_byte  <= next_tx_byte;
      got_addr <= next_got_addr;
    end
  end

  assign xf.tx_tgl   = tx_tgl;
  assign xf.tx_byte  = tx_byte;
  assign xf.drive_en = active;

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      ack_n_out     <= 1'b1;
      ack_n_oe_out  <= 1'b0;
      cmd_byte_out  <= 8'h00;
      cmd_valid_out <= 1'b0;
      selected_out  <= 1'b0;
    end else begin
      ack_n_out     <= 1'b0;
      ack_n_oe_out  <= (state == pcsp_pkg::PCSP_ST_ACK) && !sel_n_s;
      cmd_valid_out <= byte_done && got_addr && active && !sel_n_s && !addrp_s[1];
      if (byte_done) cmd_byte_out <= xf.rx_byte;
      selected_out  <= active;
    end
  end
endmodule

/* File: test/pcsp_properties.sv */
// Concurrent checks on acknowledge, selection and command pulses of the port.
`timescale 1ns/1ps
`include "pcsp_defs.svh"
module pcsp_properties (
  // Clock, reset and link inputs
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic link_clk_in,
  input wire logic port_select_n_in,
  // Watched outputs
  input wire logic ack_n_out,
  input wire logic ack_n_oe_out,
  input wire logic cmd_valid_out,
  input wire logic selected_out
);
  logic       link_q;
  logic [9:0] quiet;
  logic [9:0] ack_len;
  logic [9:0] next_quiet;
  logic [9:0] next_ack_len;
  // The link clock idles high, so time since it last moved is time since the last bit.
  always_comb begin
    next_quiet   = (link_q != link_clk_in) ? 10'h000 : quiet + {9'h000, quiet != 10'h3ff};
    next_ack_len = ack_n_oe_out ? ack_len + 10'h001 : 10'h000;
  end
  always_ff @(posedge sys_clk_in) begin
    link_q  <= link_clk_in;
    quiet   <= resetn_in ? next_quiet : 10'h000;
    ack_len <= resetn_in ? next_ack_len : 10'h000;
  end
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence s_pulse;
    cmd_valid_out ##1 !cmd_valid_out;
  endsequence
  a_ack_drives_low: assert property (ack_n_oe_out |-> !ack_n_out)
    else $error("acknowledge enabled while not low");
  a_ack_needs_select: assert property ($rose(ack_n_oe_out) |-> selected_out)
    else $error("acknowledge from an unaddressed port");
  a_ack_min_width: assert property ($fell(ack_n_oe_out) |-> ack_len == `PCSP_ACK_LOW_CYC)
    else $error("acknowledge pulse has the wrong width");
  a_ack_late_enough: assert property ($rose(ack_n_oe_out) |->
    quiet >= `PCSP_ACK_DELAY_CYC && quiet <= `PCSP_ACK_DELAY_CYC + 12)
    else $error("acknowledge not at its delay after the last bit");
  a_deselect_clears: assert property (port_select_n_in [*6] |-> !selected_out)
    else $error("still selected after select went high");
  a_select_follows_addr: assert property ($rose(selected_out) |->
    !port_select_n_in && quiet <= 10'h008)
    else $error("selection not right after an address byte");
  a_valid_while_sel: assert property (cmd_valid_out |-> selected_out && quiet <= 10'h008)
    else $error("command pulse outside a selected byte end");
  a_valid_one_pulse: assert property ($rose(cmd_valid_out) |-> s_pulse)
    else $error("command pulse longer than one cycle");
endmodule

/* File: test/pcsp_host_model.sv */
// Behavioural host port: select, serial clock and commands; samples reply and acknowledge.
`timescale 1ns/1ps
module pcsp_host_model (
  // Host-driven link pins
  output logic     link_clk_out,
  output logic     port_select_n_out,
  output logic     cmd_out,
  // Peripheral lines, resolved with their pull-ups
  input wire logic reply_in,
  input wire logic ack_n_in
);
  initial begin
    link_clk_out      = 1'b1;
    cmd_out           = 1'b1;
    // A short select pulse clears the peripheral's link state before the first frame.
    port_select_n_out = 1'b0;
    #2 port_select_n_out = 1'b1;
  end
  // This port has no lightpen status or enable bits, so that pin is not modelled.
  task automatic frame(input logic on);
    #40 port_select_n_out = !on;
    #40;
  endtask
  // Early acknowledge is ignored, and a stuck-low line cannot hang the host.
  // The acked flag stands for the byte-received status; it is not given up until the
  // acknowledge line is high again, when a level-based status could be cleared.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic acked);
    int t;
    for (int i = 0; i < 8; i++) begin
      #6 link_clk_out = 1'b0;
      cmd_out = tx[i];
      #6 link_clk_out = 1'b1;
      rx[i] = reply_in;
    end
    acked = 1'b0;
    for (t = 0; t < 100000 && !acked; t += 8)
      #8 acked = (t >= 2400) && !ack_n_in;
    for (t = 0; t < 100000 && !ack_n_in; t += 8)
      #8;
  endtask
endmodule

/* File: test/pad_card_serial_port_test.sv */
// Self-checking bench for the peripheral end of the pad card serial port.
`timescale 1ns/1ps
`include "pcsp_defs.svh"
module pad_card_serial_port_test;
  logic        sys_clk_in, resetn_in, link_clk, sel_n, cmd, hush, reply_w, ack_w;
  logic        out_line, out_oe, ack_n, ack_oe, valid, selected, last, acked, match;
  logic [7:0]  reply_byte, cmd_byte, rx;
  logic [7:0]  exp_rep[3], exp_cmd[$], got_cmd[$];
  logic [7:0]  addr_tab[5] = '{8'h81, 8'h01, 8'h21, 8'h61, 8'h81};
  logic [31:0] seed;
  int          n_fail, check_count, cycles;
  // Both lines have host pull-ups, so an undriven line reads high.
  assign reply_w = out_oe ? out_line : 1'b1;
  assign ack_w   = ack_oe ? ack_n : 1'b1;
  pcsp_port #(.DEV_ADDR(`PCSP_ADDR_CARD)) u_dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .link_clk_in(link_clk), .port_select_n_in(sel_n), .cmd_in(cmd),
    .shared_reply_line_out(out_line), .shared_reply_line_oe_out(out_oe), .ack_n_out(ack_n),
    .ack_n_oe_out(ack_oe), .reply_byte_in(reply_byte), .reply_last_in(last),
    .cmd_byte_out(cmd_byte), .cmd_valid_out(valid), .selected_out(selected));
  pcsp_host_model u_host (.link_clk_out(link_clk), .port_select_n_out(sel_n), .cmd_out(cmd),
    .reply_in(reply_w), .ack_n_in(ack_w));
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = !sys_clk_in;
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic summarize();
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic put_reply(input logic [7:0] b, input logic l);
    @(posedge sys_clk_in);
    #1 reply_byte = b;
    last = l;
  endtask
  function automatic logic [7:0] draw();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  always @(posedge link_clk) if (hush === 1'b1 && resetn_in === 1'b1) chk_bit(out_oe, 1'b0);
  // Registered outputs are taken on the falling edge, where they have settled.
  always @(negedge sys_clk_in) begin
    cycles++;
    if (valid === 1'b1) got_cmd.push_back(cmd_byte);
    if (cycles == 85000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    seed = 32'h23e6_8ae9;
    {resetn_in, hush, last, reply_byte} = 11'h000;
    repeat (3) @(posedge sys_clk_in);
    #1 resetn_in = 1'b1;
    foreach (addr_tab[f]) begin
      match = (addr_tab[f] == `PCSP_ADDR_CARD);
      foreach (exp_rep[k]) exp_rep[k] = draw();
      hush = 1'b1;
      u_host.frame(1'b1);
      put_reply(exp_rep[0], 1'b0);
      u_host.xfer(addr_tab[f], rx, acked);
      chk_bit(acked, match);
      chk_bit(selected, match);
      hush = !match;
      for (int k = 0; match && k < 3; k++) begin
        put_reply(exp_rep[k < 2 ? k + 1 : 2], k > 0);
        exp_cmd.push_back(k < 2 ? draw() : 8'h00);
        u_host.xfer(exp_cmd[k], rx, acked);
        chk_byte(rx, exp_rep[k]);
        chk_bit(acked, k < 2);
      end
      u_host.frame(1'b0);
      while (exp_cmd.size() > 0) chk_byte(got_cmd.pop_front(), exp_cmd.pop_front());
      chk_bit(got_cmd.size() == 0, 1'b1);
    end
    summarize();
  end
endmodule
bind pcsp_port pcsp_properties u_props (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
  .link_clk_in(link_clk_in), .port_select_n_in(port_select_n_in), .ack_n_out(ack_n_out),
  .ack_n_oe_out(ack_n_oe_out), .cmd_valid_out(cmd_valid_out), .selected_out(selected_out));
